// [rtl/ehcp_pkg.sv]
// Shared constants and types for the external host companion port
package ehcp_pkg;
	// Bus widths
	localparam int DATA_W = 32; // Full data path, narrow mode not allowed
	localparam int ADDR_W = 28; // Shared address lines, 256 Mbyte space
	localparam int BANKS = 4; // Memory banks decoded from address bits 25:24
	localparam int IRQ_N = 7; // Interrupt sources, index i is priority level i+1
	// Internal register window: address bits 27:24 equal to this value
	localparam logic [3:0] REG_BASE = 4'hf;
	localparam int REG_N = 4; // Words in the internal register space
	// Host size encoding: 00 long, 01 byte, 10 word, 11 line
	localparam logic [1:0] SIZ_LONG = 2'h0;
	localparam logic [1:0] SIZ_BYTE = 2'h1;
	localparam logic [1:0] SIZ_WORD = 2'h2;
	localparam logic [1:0] SIZ_LINE = 2'h3;
	// Transfer type code of an interrupt acknowledge cycle
	localparam logic [1:0] TT_IACK = 2'h3;
	// Clock timing: reference 25 MHz, internal clock 250 MHz
	localparam int REF_DIV = 5; // Half period of 25 MHz in ref_clk cycles
	localparam int LOCK_CYCLES = 64; // PLL lock time in ref_clk cycles
	localparam int HOST_MIN_MHZ = 16; // Host needs a clock of at least this
	// Reset value of the preserved configuration
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	// Interrupt output form
	typedef enum logic {EHCP_IRQ_SINGLE, EHCP_IRQ_ENCODED} ehcp_irq_mode_t;
endpackage

// [rtl/ehcp_if.sv]
// Shared host bus between the device and the external host
interface ehcp_if;
	logic [ehcp_pkg::DATA_W-1:0] data_h2d; // Write data from host
	logic [ehcp_pkg::DATA_W-1:0] data_d2h; // Read data from device
	logic data_d2h_oe; // Device drives data bus
	logic [ehcp_pkg::ADDR_W-1:0] addr; // Address from host
	logic rw; // High for read
	logic [1:0] transfer_size_bits; // Host size code
	logic transfer_start_n; // Start of a cycle, one clock
	logic transfer_ack_n; // Cycle end
	logic transfer_error_ack_n; // Cycle ended with error
	logic burst_inhibit_n; // Burst not supported
	logic [1:0] transfer_type_bits; // Type of the cycle
	logic [2:0] transfer_mode_bits; // Mode of the cycle
	logic [2:0] encoded_irq_outputs_n; // Encoded priority, active low
	logic single_irq_output_n; // Single request, active low
	logic first_clock_out; // 25 MHz, idle while locking
	logic second_clock_out; // 50 MHz once locked
	logic host_reset_input_n; // Reset to the host
	modport device (input data_h2d, addr, rw, transfer_size_bits, transfer_start_n,
		transfer_type_bits, transfer_mode_bits,
		output data_d2h, data_d2h_oe, transfer_ack_n, transfer_error_ack_n,
		burst_inhibit_n, encoded_irq_outputs_n, single_irq_output_n, first_clock_out,
		second_clock_out, host_reset_input_n);
	modport host (output data_h2d, addr, rw, transfer_size_bits, transfer_start_n,
		transfer_type_bits, transfer_mode_bits,
		input data_d2h, data_d2h_oe, transfer_ack_n, transfer_error_ack_n,
		burst_inhibit_n, encoded_irq_outputs_n, single_irq_output_n, first_clock_out,
		second_clock_out, host_reset_input_n);
endinterface

// [rtl/ehcp_device.sv]
// Device end of the host companion port: bus tracking, clocks, reset, interrupts
module ehcp_device (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Host bus
	ehcp_if.device bus,
	// Soft_reset_line and configuration
	input wire logic soft_reset_line_n,
	input wire logic boot_cs_enable,
	input wire logic pll_rewrite,
	input wire logic irq_mode_encoded,
	input wire logic [31:0] cfg_wdata,
	input wire logic cfg_we,
	output logic [31:0] cfg_q_out,
	// Interrupt sources
	input wire logic [ehcp_pkg::IRQ_N-1:0] external_irq_inputs,
	input wire logic [ehcp_pkg::IRQ_N-1:0] internal_irq,
	// Memory side
	output logic [ehcp_pkg::BANKS-1:0] bank_select_n,
	output logic [3:0] byte_write_strobes_n,
	output logic [2:0] pending_level
);
	// Host size decode to byte lane mask using host encoding
	function automatic logic [3:0] size_lanes(input logic [1:0] siz, input logic [1:0] a);
		logic [3:0] m;
		m = 4'hf;
		case (siz)
			ehcp_pkg::SIZ_BYTE: m = 4'h1 << a;
			ehcp_pkg::SIZ_WORD: m = a[1] ? 4'hc : 4'h3;
			default: m = 4'hf;
		endcase
		return m;
	endfunction

	typedef enum {ST_IDLE, ST_ACCESS, ST_ACK} ehcp_bus_st_t;
	typedef enum {CK_LOCK, CK_RUN, CK_RELOCK} ehcp_clk_st_t;

	// Power-on reset and soft reset combination
	logic por_done_q, por_done_d; // Internal power-on reset finished
	logic core_rst; // Internal logic reset
	always_comb begin
		por_done_d = 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			por_done_q <= 1'b0;
		end else begin
			por_done_q <= por_done_d;
		end
	end
	assign core_rst = !rst_n || !soft_reset_line_n || (boot_cs_enable && !por_done_q);
	assign bus.host_reset_input_n = rst_n && !(boot_cs_enable && !por_done_q);

	// Preserved configuration, cleared only by hard reset
	logic [31:0] cfg_q, cfg_d;
	always_comb begin
		cfg_d = cfg_we ? cfg_wdata : cfg_q;
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cfg_q <= ehcp_pkg::CFG_RST;
		end else begin
			cfg_q <= cfg_d;
		end
	end
	assign cfg_q_out = cfg_q;

	// Clock generation: reference divider plus lock sequencing
	ehcp_clk_st_t ck_q, ck_d;
	logic [7:0] lock_q, lock_d; // Lock counter
	logic [2:0] div_q, div_d; // Half period counter
	logic ref_q, ref_d; // 25 MHz reference phase
	logic dbl_d; // 50 MHz level, rising with every reference edge
	logic c1_q, c1_d;
	logic c2_q, c2_d;
	always_comb begin
		ck_d = ck_q;
		lock_d = lock_q;
		div_d = (div_q == 3'(ehcp_pkg::REF_DIV - 1)) ? 3'h0 : div_q + 3'h1;
		ref_d = (div_q == 3'(ehcp_pkg::REF_DIV - 1)) ? !ref_q : ref_q;
		// One period per reference half, high for three of the five cycles
		dbl_d = (div_d <= 3'(ehcp_pkg::REF_DIV / 2));
		c1_d = 1'b0;
		c2_d = 1'b0;
		case (ck_q)
			// Power-on lock: first idle, second follows reference
			CK_LOCK: begin
				c2_d = ref_d;
				lock_d = lock_q + 8'h1;
				if (lock_q == 8'(ehcp_pkg::LOCK_CYCLES - 1)) begin
					ck_d = CK_RUN;
				end
			end
			// Locked: 25 and 50 MHz
			CK_RUN: begin
				c1_d = ref_d;
				c2_d = dbl_d;
				lock_d = 8'h0;
				if (pll_rewrite) begin
					ck_d = CK_RELOCK;
				end
			end
			// Relock: both stopped
			CK_RELOCK: begin
				lock_d = lock_q + 8'h1;
				if (lock_q == 8'(ehcp_pkg::LOCK_CYCLES - 1)) begin
					ck_d = CK_RUN;
				end
			end
			default: ck_d = CK_LOCK;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ck_q <= CK_LOCK;
			lock_q <= 8'h0;
			div_q <= 3'h0;
			ref_q <= 1'b0;
			c1_q <= 1'b0;
			c2_q <= 1'b0;
		end else begin
			ck_q <= ck_d;
			lock_q <= lock_d;
			div_q <= div_d;
			ref_q <= ref_d;
			c1_q <= c1_d;
			c2_q <= c2_d;
		end
	end
	assign bus.first_clock_out = c1_q;
	assign bus.second_clock_out = c2_q;

	// Bus tracking of every host cycle
	ehcp_bus_st_t st_q, st_d;
	logic [ehcp_pkg::ADDR_W-1:0] adr_q, adr_d; // Latched host address
	logic rw_q, rw_d;
	logic [3:0] lanes_q, lanes_d;
	logic iack_q, iack_d;
	logic [ehcp_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic [ehcp_pkg::DATA_W-1:0] regs_q [ehcp_pkg::REG_N];
	logic [ehcp_pkg::DATA_W-1:0] regs_d [ehcp_pkg::REG_N];
	logic hit; // Access targets internal registers or interrupt ack
	logic [1:0] ridx;
	assign hit = (adr_q[ehcp_pkg::ADDR_W-1 -: 4] == ehcp_pkg::REG_BASE) || iack_q;
	assign ridx = adr_q[3:2];
	always_comb begin
		st_d = st_q;
		adr_d = adr_q;
		rw_d = rw_q;
		lanes_d = lanes_q;
		iack_d = iack_q;
		rdata_d = rdata_q;
		regs_d = regs_q;
		case (st_q)
			// Every start is taken, ungated
			ST_IDLE: begin
				if (!bus.transfer_start_n) begin
					adr_d = bus.addr;
					rw_d = bus.rw;
					lanes_d = size_lanes(bus.transfer_size_bits, bus.addr[1:0]);
					iack_d = (bus.transfer_type_bits == ehcp_pkg::TT_IACK);
					st_d = ST_ACCESS;
				end
			end
			// Perform register access; others left to memory
			ST_ACCESS: begin
				if (hit) begin
					if (iack_q) begin
						rdata_d = {29'h0, pending_level};
					end else if (rw_q) begin
						rdata_d = regs_q[ridx];
					end else begin
						for (int b = 0; b < 4; b++) begin
							if (lanes_q[b]) begin
								regs_d[ridx][8*b +: 8] = bus.data_h2d[8*b +: 8];
							end
						end
					end
					st_d = ST_ACK;
				end else begin
					st_d = ST_IDLE;
				end
			end
			ST_ACK: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (core_rst) begin
			st_q <= ST_IDLE;
			adr_q <= '0;
			rw_q <= 1'b1;
			lanes_q <= 4'h0;
			iack_q <= 1'b0;
			rdata_q <= '0;
			for (int i = 0; i < ehcp_pkg::REG_N; i++) begin
				regs_q[i] <= '0;
			end
		end else begin
			st_q <= st_d;
			adr_q <= adr_d;
			rw_q <= rw_d;
			lanes_q <= lanes_d;
			iack_q <= iack_d;
			rdata_q <= rdata_d;
			regs_q <= regs_d;
		end
	end
	// Host-protocol control outputs
	assign bus.transfer_ack_n = !(st_q == ST_ACK);
	assign bus.transfer_error_ack_n = 1'b1;
	assign bus.burst_inhibit_n = !(st_q == ST_ACK);
	assign bus.data_d2h = rdata_q;
	assign bus.data_d2h_oe = (st_q == ST_ACK) && rw_q;

	// Bank decode and byte strobes for memory cycles
	always_comb begin
		for (int k = 0; k < ehcp_pkg::BANKS; k++) begin
			bank_select_n[k] = !((st_q == ST_ACCESS) && !hit &&
				adr_q[ehcp_pkg::ADDR_W-3 -: 2] == 2'(k));
		end
		byte_write_strobes_n = ((st_q == ST_ACCESS) && !hit && !rw_q) ? ~lanes_q : 4'hf;
	end

	// Interrupt arbitration: highest level wins
	logic [2:0] lvl_q, lvl_d;
	always_comb begin
		lvl_d = 3'h0;
		for (int j = 0; j < ehcp_pkg::IRQ_N; j++) begin
			if (external_irq_inputs[j] || internal_irq[j]) begin
				lvl_d = 3'(j + 1);
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (core_rst) begin
			lvl_q <= 3'h0;
		end else begin
			lvl_q <= lvl_d;
		end
	end
	assign pending_level = lvl_q;
	// Output form chosen by configuration
	assign bus.encoded_irq_outputs_n = irq_mode_encoded ? ~lvl_q : 3'h7;
	assign bus.single_irq_output_n = irq_mode_encoded ? 1'b1 : (lvl_q == 3'h0);
endmodule

// [rtl/ehcp_host.sv]
// Host end of the companion port: issues cycles, waits for ack, sees interrupts
module ehcp_host (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Host bus
	ehcp_if.host bus,
	// User request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_rw,
	input wire logic [ehcp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [1:0] req_size,
	input wire logic [1:0] req_type,
	input wire logic [ehcp_pkg::DATA_W-1:0] req_wdata,
	// User answer
	output logic rsp_valid,
	output logic rsp_error,
	output logic [ehcp_pkg::DATA_W-1:0] rsp_rdata,
	// Status
	output logic [2:0] irq_level,
	output logic in_reset
);
	typedef enum {HS_IDLE, HS_START, HS_WAIT} ehcp_host_st_t;
	ehcp_host_st_t st_q, st_d;
	logic [ehcp_pkg::ADDR_W-1:0] a_q, a_d;
	logic rw_q, rw_d;
	logic [1:0] sz_q, sz_d, tt_q, tt_d;
	logic [ehcp_pkg::DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
	logic rv_q, rv_d, re_q, re_d;
	// Reset follows the device reset output
	logic hrst;
	assign hrst = !rst_n || !bus.host_reset_input_n;
	assign req_ready = (st_q == HS_IDLE) && !hrst;
	// Cycle sequencing; start and ack pass ungated
	always_comb begin
		st_d = st_q;
		a_d = a_q;
		rw_d = rw_q;
		sz_d = sz_q;
		tt_d = tt_q;
		wd_d = wd_q;
		rd_d = rd_q;
		rv_d = 1'b0;
		re_d = 1'b0;
		case (st_q)
			HS_IDLE: begin
				if (req_valid) begin
					a_d = req_addr;
					rw_d = req_rw;
					sz_d = req_size;
					tt_d = req_type;
					wd_d = req_wdata;
					st_d = HS_START;
				end
			end
			HS_START: st_d = HS_WAIT;
			HS_WAIT: begin
				if (!bus.transfer_ack_n || !bus.transfer_error_ack_n) begin
					rd_d = bus.data_d2h;
					rv_d = 1'b1;
					re_d = !bus.transfer_error_ack_n;
					st_d = HS_IDLE;
				end
			end
			default: st_d = HS_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (hrst) begin
			st_q <= HS_IDLE;
			a_q <= '0;
			rw_q <= 1'b1;
			sz_q <= ehcp_pkg::SIZ_LONG;
			tt_q <= 2'h0;
			wd_q <= '0;
			rd_q <= '0;
			rv_q <= 1'b0;
			re_q <= 1'b0;
		end else begin
			st_q <= st_d;
			a_q <= a_d;
			rw_q <= rw_d;
			sz_q <= sz_d;
			tt_q <= tt_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			rv_q <= rv_d;
			re_q <= re_d;
		end
	end
	// Bus drive
	assign bus.transfer_start_n = !(st_q == HS_START);
	assign bus.addr = a_q;
	assign bus.rw = rw_q;
	assign bus.transfer_size_bits = sz_q;
	assign bus.transfer_type_bits = tt_q;
	assign bus.transfer_mode_bits = (tt_q == ehcp_pkg::TT_IACK) ? bus.encoded_irq_outputs_n : 3'h0;
	assign bus.data_h2d = wd_q;
	assign rsp_valid = rv_q;
	assign rsp_error = re_q;
	assign rsp_rdata = rd_q;
	// Interrupt level seen from either output form
	assign irq_level = (bus.encoded_irq_outputs_n != 3'h7) ? ~bus.encoded_irq_outputs_n :
		{2'h0, !bus.single_irq_output_n};
	assign in_reset = hrst;
endmodule

// [testbench/ehcp_props.sv]
// Concurrent checks on the shared host bus between device and host ends
module ehcp_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Cycle control from the host
	input wire logic [ehcp_pkg::ADDR_W-1:0] addr,
	input wire logic rw,
	input wire logic transfer_start_n,
	input wire logic [1:0] transfer_type_bits,
	// Cycle end from the device
	input wire logic transfer_ack_n,
	input wire logic transfer_error_ack_n,
	input wire logic burst_inhibit_n,
	input wire logic data_d2h_oe,
	// Interrupts, clocks and host reset
	input wire logic [2:0] encoded_irq_outputs_n,
	input wire logic single_irq_output_n,
	input wire logic first_clock_out,
	input wire logic second_clock_out,
	input wire logic host_reset_input_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] up_q; // Cycles since reset release, saturating
	logic [7:0] up_d; // Next count
	// Count up after reset, stop at the top
	always_comb begin
		up_d = (up_q == 8'hff) ? up_q : up_q + 8'h01;
	end
	// Register the count, cleared while in reset
	always_ff @(posedge ref_clk) begin
		up_q <= rst_n ? up_d : 8'h00;
	end
	// Start of a cycle that the device answers itself
	sequence s_own_start;
		!transfer_start_n && (addr[27:24] == ehcp_pkg::REG_BASE
			|| transfer_type_bits == ehcp_pkg::TT_IACK);
	endsequence
	// Ack one idle cycle later, low for one cycle
	sequence s_ack_pulse;
		transfer_ack_n ##1 !transfer_ack_n ##1 transfer_ack_n;
	endsequence
	// One half period of the reference clock
	sequence s_ref_half;
		$stable(second_clock_out) [*4] ##1 $changed(second_clock_out);
	endsequence
	a_own_ack: assert property (s_own_start |=> s_ack_pulse)
		else $error("device cycle not acked on time");
	a_ack_cause: assert property (!transfer_ack_n |-> $past(transfer_start_n, 2) == 1'b0)
		else $error("ack without a start two cycles before");
	a_burst_inh: assert property (!transfer_ack_n |-> !burst_inhibit_n)
		else $error("burst inhibit missing at ack");
	a_no_error: assert property (transfer_error_ack_n)
		else $error("unexpected error ack");
	a_read_drive: assert property (data_d2h_oe == (!transfer_ack_n && rw))
		else $error("data drive not tied to read ack");
	a_irq_form: assert property (encoded_irq_outputs_n != 3'h7 |-> single_irq_output_n)
		else $error("both interrupt forms active");
	a_lock_idle: assert property (up_q < 8'h3c |-> !first_clock_out)
		else $error("first clock runs during lock");
	a_lock_ref: assert property (up_q == 8'h08 |-> ##[0:4] $changed(second_clock_out)
		##1 s_ref_half ##1 s_ref_half)
		else $error("second clock not at reference rate in lock");
	a_host_reset: assert property (disable iff (1'b0) !rst_n |-> !host_reset_input_n)
		else $error("host reset not low in reset");
endmodule

// [testbench/external_host_companion_port_tb.sv]
// Self-checking bench joining the device and host ends
module external_host_companion_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0; // 250 MHz
	logic rst_n = 1'b0;
	logic soft_reset_n = 1'b1, boot_cs = 1'b0, pll_rewrite = 1'b0, irq_enc = 1'b0;
	logic cfg_we = 1'b0, req_valid = 1'b0, req_rw = 1'b0;
	logic [31:0] cfg_wdata = 32'h0, req_wdata = 32'h0, cfg_q, rsp_rdata, rd, nb, nb2, r;
	logic [31:0] wv[4]; // Words written to the registers
	logic [27:0] req_addr = 28'h0;
	logic [1:0] req_size = 2'h0, req_type = 2'h0;
	logic [6:0] ext_irq = 7'h0, int_irq = 7'h0, top, low;
	logic [2:0] pend_lvl;
	logic req_ready, rsp_valid, rsp_error;
	logic c1p, c2p; // Clock levels one cycle back
	logic [2:0] host_lvl; // Interrupt level as the host sees it
	logic host_rst; // Host held in reset
	logic [32:0] exp_q[$]; // Expected answers; bit 32 set when read data counts
	logic [32:0] exp_note;
	int mismatches = 0;
	int tests_run = 0;
	int seed = 32'h4b778169;
	int i, s, k;
	ehcp_if ehcp_if_inst ();
	ehcp_device ehcp_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(ehcp_if_inst),
		.soft_reset_line_n(soft_reset_n), .boot_cs_enable(boot_cs), .pll_rewrite(pll_rewrite),
		.irq_mode_encoded(irq_enc), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we), .cfg_q_out(cfg_q),
		.external_irq_inputs(ext_irq), .internal_irq(int_irq), .bank_select_n(),
		.byte_write_strobes_n(), .pending_level(pend_lvl));
	ehcp_host ehcp_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(ehcp_if_inst),
		.req_valid(req_valid), .req_ready(req_ready), .req_rw(req_rw), .req_addr(req_addr),
		.req_size(req_size), .req_type(req_type), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
		.irq_level(host_lvl), .in_reset(host_rst));
	ehcp_props ehcp_props_inst (.ref_clk(ref_clk), .rst_n(rst_n), .addr(ehcp_if_inst.addr),
		.rw(ehcp_if_inst.rw), .transfer_start_n(ehcp_if_inst.transfer_start_n),
		.transfer_type_bits(ehcp_if_inst.transfer_type_bits),
		.transfer_ack_n(ehcp_if_inst.transfer_ack_n),
		.transfer_error_ack_n(ehcp_if_inst.transfer_error_ack_n),
		.burst_inhibit_n(ehcp_if_inst.burst_inhibit_n), .data_d2h_oe(ehcp_if_inst.data_d2h_oe),
		.encoded_irq_outputs_n(ehcp_if_inst.encoded_irq_outputs_n),
		.single_irq_output_n(ehcp_if_inst.single_irq_output_n),
		.first_clock_out(ehcp_if_inst.first_clock_out),
		.second_clock_out(ehcp_if_inst.second_clock_out),
		.host_reset_input_n(ehcp_if_inst.host_reset_input_n));
	// Clock toggles every half period
	always #2 ref_clk = ~ref_clk;
	// Compares one value and counts
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			mismatches++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// Prints counts and verdict, then stops
	task automatic end_of_test();
		$display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Address of one internal register word
	function automatic logic [27:0] reg_addr(input int w);
		return {ehcp_pkg::REG_BASE, 20'h0, w[1:0], 2'h0};
	endfunction
	// One host cycle: note the answer, hold the request until taken, wait for it
	task automatic bus_op(input logic rw, input logic [27:0] a, input logic [1:0] sz,
		input logic [1:0] ty, input logic [31:0] wd, input logic [32:0] note,
		output logic [31:0] got);
		int n;
		exp_q.push_back(note);
		req_valid <= 1'b1;
		req_rw <= rw;
		req_addr <= a;
		req_size <= sz;
		req_type <= ty;
		req_wdata <= wd;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 50);
		// A cycle that never ends counts as a mismatch and closes the run
		if (rsp_valid !== 1'b1) begin
			mismatches++;
			end_of_test();
		end
		got = rsp_rdata;
	endtask
	// Takes the oldest note whenever an answer comes back
	always @(posedge ref_clk) begin
		if (rst_n && rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(32'h1, 32'h0);
			end else begin
				exp_note = exp_q.pop_front();
				check({31'h0, rsp_error}, 32'h0);
				if (exp_note[32])
					check(rsp_rdata, exp_note[31:0]);
			end
		end
	end
	// Cuts a hang short, far beyond the expected run
	initial begin
		#20000;
		mismatches++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Random words written, then read back
		for (i = 0; i < 4; i++) begin
			wv[i] = $random(seed);
			bus_op(1'b0, reg_addr(i), ehcp_pkg::SIZ_LONG, 2'h0, wv[i], 33'h0, rd);
		end
		for (i = 0; i < 4; i++)
			bus_op(1'b1, reg_addr(i), 2'h0, 2'h0, 32'h0, {1'b1, wv[i]}, rd);
		$display("Test registers done");
		// Ones over zeros with each size code, count the bytes that changed
		for (s = 0; s < 4; s++) begin
			bus_op(1'b0, reg_addr(1), ehcp_pkg::SIZ_LONG, 2'h0, 32'h0, 33'h0, rd);
			bus_op(1'b0, reg_addr(1), s[1:0], 2'h0, 32'hffffffff, 33'h0, rd);
			bus_op(1'b1, reg_addr(1), ehcp_pkg::SIZ_LONG, 2'h0, 32'h0, 33'h0, rd);
			nb = 32'h0;
			for (k = 0; k < 4; k++)
				if (rd[8*k+:8] === 8'hff)
					nb = nb + 32'h1;
			check(nb, (s == 1) ? 32'h1 : (s == 2) ? 32'h2 : 32'h4);
		end
		$display("Test sizes done");
		// Each level, odd ones from internal sources in encoded form, even ones from external sources in single form, then acknowledged
		for (i = 1; i < 8; i++) begin
			r = $random(seed);
			top = 7'h1 << (i - 1);
			low = top - 7'h1;
			irq_enc <= i[0];
			int_irq <= i[0] ? top : (r[6:0] & low);
			ext_irq <= i[0] ? (r[13:7] & low) : top;
			repeat (4) @(posedge ref_clk);
			check({29'h0, pend_lvl}, 32'(i));
			check({29'h0, ehcp_if_inst.encoded_irq_outputs_n}, i[0] ? {29'h0, ~i[2:0]} : 32'h7);
			check({29'h0, host_lvl}, i[0] ? 32'(i) : 32'h1);
			check({31'h0, ehcp_if_inst.single_irq_output_n}, 32'(i[0]));
			bus_op(1'b1, 28'h0, 2'h0, ehcp_pkg::TT_IACK, 32'h0, {1'b1, 29'h0, i[2:0]}, rd);
		end
		int_irq <= 7'h0;
		ext_irq <= 7'h0;
		repeat (4) @(posedge ref_clk);
		check({29'h0, pend_lvl}, 32'h0);
		$display("Test interrupts done");
		// Soft reset keeps the configuration
		r = $random(seed);
		cfg_we <= 1'b1;
		cfg_wdata <= r;
		@(posedge ref_clk);
		cfg_we <= 1'b0;
		soft_reset_n <= 1'b0;
		@(posedge ref_clk);
		soft_reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		check(cfg_q, r);
		// Internal registers are cleared by the soft reset
		bus_op(1'b1, reg_addr(0), ehcp_pkg::SIZ_LONG, 2'h0, 32'h0, {1'b1, 32'h0}, rd);
		$display("Test soft reset done");
		// Relock stops both clocks, then they run at their rates again
		pll_rewrite <= 1'b1;
		@(posedge ref_clk);
		pll_rewrite <= 1'b0;
		nb = 32'h0;
		repeat (3) @(posedge ref_clk);
		for (k = 0; k < 55; k++) begin
			@(posedge ref_clk);
			#1;
			if (ehcp_if_inst.first_clock_out !== 1'b0 || ehcp_if_inst.second_clock_out !== 1'b0)
				nb = nb + 32'h1;
		end
		check(nb, 32'h0);
		repeat (30) @(posedge ref_clk);
		nb = 32'h0;
		nb2 = 32'h0;
		@(posedge ref_clk);
		#1;
		c1p = ehcp_if_inst.first_clock_out;
		c2p = ehcp_if_inst.second_clock_out;
		for (k = 0; k < 20; k++) begin
			@(posedge ref_clk);
			#1;
			if (ehcp_if_inst.first_clock_out !== c1p)
				nb = nb + 32'h1;
			if (ehcp_if_inst.second_clock_out !== c2p)
				nb2 = nb2 + 32'h1;
			c1p = ehcp_if_inst.first_clock_out;
			c2p = ehcp_if_inst.second_clock_out;
		end
		check(nb, 32'h4);
		check(nb2, 32'h8);
		$display("Test clocks done");
		@(posedge ref_clk);
		// Reset with the boot select adds one cycle of host reset
		boot_cs <= 1'b1;
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		check({31'h0, ehcp_if_inst.host_reset_input_n}, 32'h0);
		check({31'h0, host_rst}, 32'h1);
		repeat (4) @(posedge ref_clk);
		#1;
		check({31'h0, ehcp_if_inst.host_reset_input_n}, 32'h1);
		$display("Test boot reset done");
		check(32'(exp_q.size()), 32'h0);
		end_of_test();
	end
endmodule
